/* esmc_pkg.sv */
// shared constants for the synchronous ethernet port control block
package esmc_pkg;
    // wishbone register byte offsets
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] TXQL_OFS   = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;
    localparam logic [7:0] COUNT_OFS  = 8'h0c;
    // control fields
    localparam int CTRL_SYNC_BIT = 0;
    localparam int CTRL_ESMC_BIT = 1;
    localparam int CTRL_QL_BIT   = 2;
    localparam logic [2:0] CTRL_RESET = 3'h0;
    localparam logic [3:0] TXQL_RESET = 4'h0;
    // status fields
    localparam int ST_CLKSEL_BIT = 0;
    localparam int ST_ESMC_BIT   = 1;
    localparam int ST_QL_BIT     = 2;
    localparam int ST_REFSEL_BIT = 3;
    localparam int ST_RXQL_LSB   = 8;
    // timing
    localparam longint CLK_PERIOD_NS = 10;
    localparam longint ONE_SEC_NS    = 1000000000;
    localparam int     SEC_CYCLES    = int'(ONE_SEC_NS / CLK_PERIOD_NS);
    localparam int     TICK_W        = 27;
    // asynchronous line rate, kept for reference by clock planning
    localparam int     LINE_FREQ_KHZ = 125000;
    localparam int     LINE_TOL_PPM  = 100;
    // slow protocol budget and frame layout
    localparam logic [3:0] SLOW_LIMIT    = 4'ha;
    localparam logic [47:0] SLOW_DA      = 48'h0180c2000002;
    localparam logic [15:0] SLOW_TYPE    = 16'h8809;
    localparam logic [7:0]  ESMC_SUBTYPE = 8'h0a;
    localparam logic [23:0] ITU_OUI      = 24'h0019a7;
    localparam logic [15:0] ITU_SUBTYPE  = 16'h0001;
    localparam logic [7:0]  ESMC_VER     = 8'h10;
    localparam logic [7:0]  QL_TLV_TYPE  = 8'h01;
    localparam logic [15:0] QL_TLV_LEN   = 16'h0004;
    localparam logic [3:0]  QL_DNU       = 4'hf;
    localparam logic [5:0]  SSM_IDX      = 6'h1b;
    localparam logic [5:0]  MATCH_IDX    = 6'h0e;
    localparam logic [5:0]  FRAME_LAST   = 6'h3b;
    // local source address, arbitrary value
    localparam logic [47:0] LOCAL_SA     = 48'h020000000001;

    typedef enum logic [0:0] {
        GEN_IDLE = 1'b0,
        GEN_SEND = 1'b1
    } gen_state_t;
endpackage

/* sec_tick.sv */
// one-second tick generator
`timescale 1ns/1ns
`default_nettype none
module sec_tick
    import esmc_pkg::*;
#(
    parameter int PERIOD = SEC_CYCLES
)(
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // tick out
    output logic      tick_o
);
    logic [TICK_W-1:0] cnt_r;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            cnt_r <= '0;
        else if (cnt_r == TICK_W'(PERIOD - 1))
            cnt_r <= '0;
        else
            cnt_r <= cnt_r + 1'b1;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            tick_o <= 1'b0;
        else
            tick_o <= (cnt_r == TICK_W'(PERIOD - 1));
    end
endmodule
`default_nettype wire

/* pair_buf.sv */
// two-entry byte buffer with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module pair_buf (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // fill side
    input  wire logic [8:0] in_data_i,
    input  wire logic       in_valid_i,
    output logic            in_ready_o,
    // drain side
    output logic [8:0]      out_data_o,
    output logic            out_valid_o,
    input  wire logic       out_ready_i
);
    logic [8:0] mem_r [2];
    logic       wp_r;
    logic       rp_r;
    logic [1:0] cnt_r;
    logic       push;
    logic       pop;

    assign in_ready_o  = (cnt_r != 2'h2);
    assign out_valid_o = (cnt_r != 2'h0);
    assign out_data_o  = mem_r[rp_r];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    always_ff @(posedge clk_i)
    begin
        if (push)
            mem_r[wp_r] <= in_data_i;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wp_r  <= 1'b0;
            rp_r  <= 1'b0;
            cnt_r <= 2'h0;
        end
        else
        begin
            wp_r  <= wp_r ^ push;
            rp_r  <= rp_r ^ pop;
            cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule
`default_nettype wire

/* esmc_port_ctrl.sv */
// synchronous ethernet user network port: clock select, esmc tx/rx, slow protocol budget
`timescale 1ns/1ns
`default_nettype none
module esmc_port_ctrl
    import esmc_pkg::*;
#(
    parameter int SEC_PERIOD = SEC_CYCLES
)(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic [31:0]      dat_o,
    output logic             ack_o,
    // clocking
    output logic             clk_sel_sync_o,
    output logic             ref_selectable_o,
    // other slow protocol clients
    input  wire logic        slow_req_i,
    output logic             slow_grant_o,
    // esmc transmit byte stream
    output logic [7:0]       tx_data_o,
    output logic             tx_last_o,
    output logic             tx_valid_o,
    input  wire logic        tx_ready_i,
    // receive byte stream
    input  wire logic [7:0]  rx_data_i,
    input  wire logic        rx_valid_i,
    input  wire logic        rx_last_i,
    // quality level seen from the peer
    output logic [3:0]       rx_ql_o
);
    logic [2:0]  ctrl_r;
    logic [3:0]  txql_r;
    logic        sync_on;
    logic        esmc_on;
    logic        ql_on;
    logic        tick;
    logic [3:0]  slow_cnt_r;
    logic        sent_r;
    logic        pend_r;
    logic        start;
    gen_state_t  state_r;
    logic [5:0]  tidx_r;
    logic [7:0]  tbyte;
    logic        bin_ready;
    logic        push;
    logic [8:0]  bout;
    logic [5:0]  ridx_r;
    logic        rmatch_r;
    logic [3:0]  rssm_r;
    logic [7:0]  rexp;
    logic        rx_end;
    logic [7:0]  tx_cnt_r;
    logic [7:0]  rx_cnt_r;
    logic [7:0]  drop_cnt_r;

    // the esmc enable bit is never read: esmc follows sync mode, forced on with it and off without it
    assign sync_on = ctrl_r[CTRL_SYNC_BIT];
    assign esmc_on = sync_on;
    assign ql_on   = sync_on & esmc_on;
    assign clk_sel_sync_o   = sync_on;
    assign ref_selectable_o = ~(sync_on & esmc_on);
    // no link aggregation state enters any of this logic

    // wishbone: one wait state, ack drops the cycle after it is given
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack_o <= 1'b0;
        else
            ack_o <= cyc_i & stb_i & ~ack_o;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl_r <= CTRL_RESET;
            txql_r <= TXQL_RESET;
        end
        else if (cyc_i & stb_i & we_i & ~ack_o & sel_i[0])
        begin
            if (adr_i == CTRL_OFS)
                ctrl_r <= dat_i[2:0];
            if (adr_i == TXQL_OFS)
                txql_r <= dat_i[3:0];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            dat_o <= '0;
        else if (cyc_i & stb_i & ~we_i & ~ack_o)
        begin
            unique case (adr_i)
                CTRL_OFS:   dat_o <= {29'h0, ctrl_r};
                TXQL_OFS:   dat_o <= {28'h0, txql_r};
                STATUS_OFS: dat_o <= {20'h0, rx_ql_o, 4'h0, ref_selectable_o, ql_on, esmc_on, clk_sel_sync_o};
                COUNT_OFS:  dat_o <= {8'h0, drop_cnt_r, rx_cnt_r, tx_cnt_r};
                default:    dat_o <= '0;
            endcase
        end
    end

    sec_tick #(
        .PERIOD (SEC_PERIOD)
    ) u_tick (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .tick_o (tick)
    );

    // one slot per second is held back for esmc so other clients cannot starve it
    assign start = pend_r & (state_r == GEN_IDLE) & (slow_cnt_r < SLOW_LIMIT);
    assign slow_grant_o = slow_req_i & ~start
                        & ((slow_cnt_r + {3'h0, esmc_on & ~sent_r}) < SLOW_LIMIT);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            slow_cnt_r <= 4'h0;
        else if (tick)
            // a grant or start in the tick cycle is charged to the new second, never lost
            slow_cnt_r <= {3'h0, start} + {3'h0, slow_grant_o};
        else
            slow_cnt_r <= slow_cnt_r + {3'h0, start} + {3'h0, slow_grant_o};
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pend_r <= 1'b0;
            sent_r <= 1'b0;
        end
        else
        begin
            pend_r <= esmc_on & ~start & (tick | pend_r);
            sent_r <= start | (~tick & sent_r);
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_r <= GEN_IDLE;
            tidx_r  <= 6'h0;
        end
        else
        begin
            unique case (state_r)
                GEN_IDLE:
                begin
                    tidx_r <= 6'h0;
                    if (start)
                        state_r <= GEN_SEND;
                end
                GEN_SEND:
                begin
                    if (push)
                    begin
                        tidx_r <= tidx_r + 6'h1;
                        if (tidx_r == FRAME_LAST)
                            state_r <= GEN_IDLE;
                    end
                end
            endcase
        end
    end

    // frame content by byte index
    always_comb
    begin
        unique case (tidx_r)
            6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05:
                tbyte = SLOW_DA[8'(6'h2f - 6'h08 * tidx_r) -: 8];
            6'h06, 6'h07, 6'h08, 6'h09, 6'h0a, 6'h0b:
                tbyte = LOCAL_SA[8'(6'h2f - 6'h08 * (tidx_r - 6'h06)) -: 8];
            6'h0c:   tbyte = SLOW_TYPE[15:8];
            6'h0d:   tbyte = SLOW_TYPE[7:0];
            6'h0e:   tbyte = ESMC_SUBTYPE;
            6'h0f:   tbyte = ITU_OUI[23:16];
            6'h10:   tbyte = ITU_OUI[15:8];
            6'h11:   tbyte = ITU_OUI[7:0];
            6'h12:   tbyte = ITU_SUBTYPE[15:8];
            6'h13:   tbyte = ITU_SUBTYPE[7:0];
            6'h14:   tbyte = ESMC_VER;
            6'h18:   tbyte = QL_TLV_TYPE;
            6'h19:   tbyte = QL_TLV_LEN[15:8];
            6'h1a:   tbyte = QL_TLV_LEN[7:0];
            6'h1b:   tbyte = {4'h0, ql_on ? txql_r : QL_DNU};
            default: tbyte = 8'h00;
        endcase
    end

    assign push = (state_r == GEN_SEND) & bin_ready;

    pair_buf u_buf (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .in_data_i   ({tidx_r == FRAME_LAST, tbyte}),
        .in_valid_i  (state_r == GEN_SEND),
        .in_ready_o  (bin_ready),
        .out_data_o  (bout),
        .out_valid_o (tx_valid_o),
        .out_ready_i (tx_ready_i)
    );
    assign tx_data_o = bout[7:0];
    assign tx_last_o = bout[8];

    // receive parser: header match through the subtype, then the quality byte
    always_comb
    begin
        unique case (ridx_r)
            6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05:
                rexp = SLOW_DA[8'(6'h2f - 6'h08 * ridx_r) -: 8];
            6'h0c:   rexp = SLOW_TYPE[15:8];
            6'h0d:   rexp = SLOW_TYPE[7:0];
            6'h0e:   rexp = ESMC_SUBTYPE;
            default: rexp = rx_data_i;
        endcase
    end

    assign rx_end = rx_valid_i & rx_last_i;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ridx_r   <= 6'h0;
            rmatch_r <= 1'b1;
            rssm_r   <= 4'h0;
        end
        else if (rx_valid_i)
        begin
            ridx_r   <= rx_last_i ? 6'h0 : ((ridx_r == 6'h3f) ? ridx_r : ridx_r + 6'h1);
            rmatch_r <= rx_last_i | (rmatch_r & (rx_data_i == rexp));
            if (ridx_r == SSM_IDX)
                rssm_r <= rx_data_i[3:0];
        end
    end

    // a frame counts only if it ran at least one byte past the quality byte
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rx_ql_o    <= QL_DNU;
            rx_cnt_r   <= 8'h0;
            drop_cnt_r <= 8'h0;
        end
        else if (rx_end & rmatch_r & (ridx_r > SSM_IDX))
        begin
            if (esmc_on)
            begin
                rx_cnt_r <= rx_cnt_r + 8'h1;
                if (ql_on)
                    rx_ql_o <= rssm_r;
            end
            else
                drop_cnt_r <= drop_cnt_r + 8'h1;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            tx_cnt_r <= 8'h0;
        else if (start)
            tx_cnt_r <= tx_cnt_r + 8'h1;
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    async_off_a: assert property (!sync_on |-> !esmc_on && !ql_on)
        else $error("esmc or quality active with sync mode off");
    clk_src_a: assert property (clk_sel_sync_o == ctrl_r[CTRL_SYNC_BIT])
        else $error("clock select does not follow sync mode");
    esmc_forced_a: assert property (sync_on |-> esmc_on && ql_on)
        else $error("sync mode without esmc and quality");
    ref_block_a: assert property (sync_on && esmc_on |-> !ref_selectable_o)
        else $error("port offered as clock reference");
    budget_cap_a: assert property (slow_cnt_r <= SLOW_LIMIT)
        else $error("slow protocol budget exceeded");
    no_gen_a: assert property (!esmc_on && state_r == GEN_IDLE && !pend_r |=> state_r == GEN_IDLE)
        else $error("esmc frame started while disabled");
    dest_addr_a: assert property (push && tidx_r == 6'h00 |-> tbyte == SLOW_DA[47:40])
        else $error("esmc frame not sent to slow protocol address");
    dnu_send_a: assert property (push && tidx_r == SSM_IDX && !ql_on |-> tbyte[3:0] == QL_DNU)
        else $error("quality sent while quality processing off");
    drop_rx_a: assert property (!esmc_on && rx_end |=> $stable(rx_ql_o) && $stable(rx_cnt_r))
        else $error("esmc frame acted on while disabled");
    tick_start_a: assert property (tick && esmc_on && state_r == GEN_IDLE && !pend_r
                                   |=> ##[0:2] start)
        else $error("esmc frame not started after tick");
    ql_forced_a: assert property (sync_on && esmc_on |-> ql_on)
        else $error("quality processing off with sync and esmc on");
    one_frame_a: assert property (sent_r && !tick |-> !start)
        else $error("second esmc frame started within one second");
    limit_hold_a: assert property (slow_cnt_r == SLOW_LIMIT |-> !slow_grant_o && !start)
        else $error("slow frame let through at the limit");
    budget_fresh_a: assert property (tick && !start && !slow_grant_o |=> slow_cnt_r == 4'h0)
        else $error("slow budget not renewed at tick");
    frame_end_a: assert property (push && tidx_r == FRAME_LAST |=> state_r == GEN_IDLE)
        else $error("generator did not stop after last byte");
    rx_take_a: assert property (esmc_on && rx_end && rmatch_r && ridx_r > SSM_IDX
                                |=> rx_cnt_r == $past(rx_cnt_r) + 8'h1)
        else $error("accepted esmc frame not counted");
    drop_count_a: assert property (!esmc_on && rx_end && rmatch_r && ridx_r > SSM_IDX
                                   |=> drop_cnt_r == $past(drop_cnt_r) + 8'h1)
        else $error("discarded esmc frame not counted");
    ql_take_a: assert property (ql_on && rx_end && rmatch_r && ridx_r > SSM_IDX
                                |=> rx_ql_o == $past(rssm_r))
        else $error("received quality not taken with quality processing on");
endmodule
`default_nettype wire

/* peer_port.sv */
// peer ethernet port model: takes the esmc byte stream and sends frames back
`timescale 1ns/1ns
`default_nettype none
module peer_port
    import esmc_pkg::*;
(
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // stream from the block
    input  wire logic [7:0] tx_data_i,
    input  wire logic       tx_last_i,
    input  wire logic       tx_valid_i,
    output logic            tx_ready_o,
    // stall control
    input  wire logic       stall_i,
    // stream into the block
    output logic [7:0]      rx_data_o,
    output logic            rx_valid_o,
    output logic            rx_last_o
);
    logic [7:0] cap [0:63];
    int         cap_n;
    int         frames;
    int         last_pos;
    logic [1:0] ph_r;

    // stalls two cycles in four so the buffer fills and must hold its words
    assign tx_ready_o = !stall_i || ph_r[1];

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ph_r     <= 2'h0;
            cap_n    <= 0;
            frames   <= 0;
            last_pos <= -1;
        end
        else
        begin
            ph_r <= ph_r + 2'h1;
            if (tx_valid_i && tx_ready_o)
            begin
                if (cap_n < 64)
                    cap[cap_n] <= tx_data_i;
                cap_n <= tx_last_i ? 0 : cap_n + 1;
                if (tx_last_i)
                begin
                    frames   <= frames + 1;
                    last_pos <= cap_n;
                end
            end
        end
    end

    initial
    begin
        rx_data_o  = 8'h00;
        rx_valid_o = 1'b0;
        rx_last_o  = 1'b0;
    end

    // idle data shows the inverse of the last byte, never a stale copy
    task automatic send(input logic [7:0] b [0:63], input int len);
        for (int i = 0; i < len; i++)
        begin
            @(posedge clk_i);
            rx_valid_o <= 1'b1;
            rx_data_o  <= b[i];
            rx_last_o  <= (i == len - 1);
        end
        @(posedge clk_i);
        rx_valid_o <= 1'b0;
        rx_last_o  <= 1'b0;
        rx_data_o  <= ~b[len - 1];
    endtask
endmodule
`default_nettype wire

/* tb.sv */
// self-checking bench for the esmc port control block
`timescale 1ns/1ns
`default_nettype none
module tb;
    import esmc_pkg::*;
    localparam int SP = 200;
    logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, slow_req_i, slow_grant_o, stall;
    logic [7:0]  adr_i, tx_data_o, rx_data_i;
    logic [3:0]  sel_i, rx_ql_o;
    logic [31:0] dat_i, dat_o, rd;
    logic        clk_sel_sync_o, ref_selectable_o, tx_last_o, tx_valid_o, tx_ready_i, rx_valid_i, rx_last_i;
    logic [7:0]  fr [0:63];
    int          n_errors, check_count, cyc_n, f0;

    esmc_port_ctrl #(.SEC_PERIOD(SP)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .clk_sel_sync_o(clk_sel_sync_o), .ref_selectable_o(ref_selectable_o), .slow_req_i(slow_req_i),
        .slow_grant_o(slow_grant_o), .tx_data_o(tx_data_o), .tx_last_o(tx_last_o), .tx_valid_o(tx_valid_o),
        .tx_ready_i(tx_ready_i), .rx_data_i(rx_data_i), .rx_valid_i(rx_valid_i), .rx_last_i(rx_last_i),
        .rx_ql_o(rx_ql_o));
    peer_port peer_u (.clk_i(clk_i), .rst_i(rst_i), .tx_data_i(tx_data_o), .tx_last_i(tx_last_o),
        .tx_valid_i(tx_valid_o), .tx_ready_o(tx_ready_i), .stall_i(stall), .rx_data_o(rx_data_i),
        .rx_valid_o(rx_valid_i), .rx_last_o(rx_last_i));

    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic stop_test();
        $display("checks %0d, mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // timeout well above the roughly 14 tick periods the run needs
    always @(posedge clk_i)
    begin
        cyc_n++;
        if (cyc_n == 40 * SP)
        begin
            n_errors++;
            stop_test();
        end
    end

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        dat_i <= d;
        @(posedge clk_i);
        while (ack_o !== 1'b1 && n < 20)
        begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 20)
        begin
            n_errors++;
            stop_test();
        end
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
    endtask

    // expected frame content worked out from the slow protocol constants
    function automatic logic [7:0] exp_byte(input int i, input logic [3:0] q);
        logic [215:0] hdr;
        hdr = {SLOW_DA, LOCAL_SA, SLOW_TYPE, ESMC_SUBTYPE, ITU_OUI, ITU_SUBTYPE, ESMC_VER, 24'h0,
               QL_TLV_TYPE, QL_TLV_LEN};
        if (i < 27)
            return hdr[215 - 8 * i -: 8];
        return (i == 27) ? {4'h0, q} : 8'h00;
    endfunction

    task automatic peer_send(input logic [3:0] q, input int len, input logic bad);
        for (int i = 0; i < 64; i++)
            fr[i] = exp_byte(i, q);
        if (bad)
            fr[0] = 8'h03;
        peer_u.send(fr, len);
        repeat (2) @(posedge clk_i);
    endtask

    task automatic wait_frames(input int n);
        int k;
        k = 0;
        while (peer_u.frames < n && k < 3 * SP)
        begin
            @(posedge clk_i);
            k++;
        end
        if (peer_u.frames < n)
        begin
            n_errors++;
            stop_test();
        end
    endtask

    // hold the request a full second first, so the window sees steady state
    task automatic t_budget(input int exp);
        int g;
        g = 0;
        slow_req_i <= 1'b1;
        repeat (SP) @(posedge clk_i);
        repeat (SP)
        begin
            @(posedge clk_i);
            if (slow_grant_o === 1'b1)
                g++;
        end
        slow_req_i <= 1'b0;
        check("grants per second", g, exp);
    endtask

    task automatic t_reset();
        check("clk_sel", clk_sel_sync_o, 1'b0);
        check("ref_sel", ref_selectable_o, 1'b1);
        wb(1'b0, STATUS_OFS, 32'h0);
        check("status reset", rd, 32'h00000f08);
        wb(1'b0, CTRL_OFS, 32'h0);
        check("ctrl reset", rd, {29'h0, CTRL_RESET});
        wb(1'b0, TXQL_OFS, 32'h0);
        check("txql reset", rd, {28'h0, TXQL_RESET});
        wb(1'b0, 8'h10, 32'h0);
        check("unmapped", rd, 32'h0);
    endtask

    task automatic t_async();
        peer_send(4'h5, 60, 1'b0);
        check("rx_ql async", rx_ql_o, QL_DNU);
        wb(1'b0, COUNT_OFS, 32'h0);
        check("count async", rd, 32'h00010000);
        repeat (2 * SP + 10) @(posedge clk_i);
        check("frames async", peer_u.frames, 0);
        t_budget(10);
    endtask

    task automatic t_sync();
        stall <= 1'b1;
        wb(1'b1, CTRL_OFS, 32'h1);
        wb(1'b1, TXQL_OFS, 32'h3);
        check("clk_sel sync", clk_sel_sync_o, 1'b1);
        check("ref_sel sync", ref_selectable_o, 1'b0);
        wb(1'b1, STATUS_OFS, 32'h0);
        wb(1'b0, STATUS_OFS, 32'h0);
        check("status sync", rd, 32'h00000f07);
        wait_frames(1);
        for (int i = 0; i < 60; i++)
            check("tx byte", peer_u.cap[i], exp_byte(i, 4'h3));
        check("last pos", peer_u.last_pos, 59);
        repeat (2 * SP + SP / 2) @(posedge clk_i);
        check("frames per second", peer_u.frames, 3);
        wb(1'b0, COUNT_OFS, 32'h0);
        // four starts by now: the fourth frame began at its tick and is still on the wire
        check("count sync", rd, 32'h00010004);
        t_budget(9);
    endtask

    task automatic t_rx();
        peer_send(4'h5, 60, 1'b0);
        check("rx_ql good", rx_ql_o, 4'h5);
        peer_send(4'h9, 60, 1'b1);
        check("rx_ql bad da", rx_ql_o, 4'h5);
        peer_send(4'h9, 20, 1'b0);
        check("rx_ql short", rx_ql_o, 4'h5);
        peer_send(4'h2, 60, 1'b0);
        wb(1'b0, STATUS_OFS, 32'h0);
        check("status rx_ql", rd[11:8], 4'h2);
        wb(1'b0, COUNT_OFS, 32'h0);
        check("rx accepted", rd[15:8], 8'h02);
    endtask

    task automatic t_off();
        wb(1'b1, CTRL_OFS, 32'h6);
        check("clk_sel off", clk_sel_sync_o, 1'b0);
        check("ref_sel off", ref_selectable_o, 1'b1);
        wb(1'b0, STATUS_OFS, 32'h0);
        check("status off", rd[3:0], 4'h8);
        repeat (SP) @(posedge clk_i);
        f0 = peer_u.frames;
        repeat (2 * SP + 10) @(posedge clk_i);
        check("frames off", peer_u.frames, f0);
    endtask

    initial
    begin
        n_errors    = 0;
        check_count = 0;
        cyc_n       = 0;
        rst_i       = 1'b1;
        cyc_i       = 1'b0;
        stb_i       = 1'b0;
        we_i        = 1'b0;
        adr_i       = 8'h00;
        sel_i       = 4'hf;
        dat_i       = 32'h0;
        slow_req_i  = 1'b0;
        stall       = 1'b0;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_async();
        t_sync();
        t_rx();
        t_off();
        stop_test();
    end
endmodule
`default_nettype wire
